// ### verilog/pec_pkg.sv
// Package: constants and types for the protection element comparator
package pec_pkg;
  localparam int unsigned PEC_VAL_W     = 16;
  localparam int unsigned PEC_GROUPS    = 8;
  localparam int unsigned PEC_GRP_W     = 3;
  localparam int unsigned PEC_DLY_W     = 16;
  localparam int unsigned PEC_CT_W      = 12;
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned TICK_US       = 1000;
  localparam int unsigned TICK_CYCLES   = (CLK_HZ / 1_000_000) * TICK_US;
  localparam logic [15:0] TICK_DIV_LAST = 16'(TICK_CYCLES - 1);
  localparam logic [15:0] DLY_RESET     = 16'h0000;
  typedef enum logic [1:0] {pec_tgt_disabled, pec_tgt_self_reset, pec_tgt_latched} pec_target_e;
  typedef enum logic [1:0] {pec_cmp_over, pec_cmp_under, pec_cmp_range} pec_cmp_e;
  typedef struct packed {
    logic [PEC_VAL_W-1:0] pickup_lo;
    logic [PEC_VAL_W-1:0] pickup_hi;
    logic [PEC_DLY_W-1:0] pickup_delay;
    logic [PEC_DLY_W-1:0] reset_delay;
  } pec_group_s;
endpackage

// ### verilog/pec_scale_if.sv
// Interface: two-transformer current summing request and result
`timescale 1ns/100ps
interface pec_scale_if;
  import pec_pkg::*;
  logic [PEC_VAL_W-1:0] cur_a;
  logic [PEC_VAL_W-1:0] cur_b;
  logic [PEC_CT_W-1:0]  ratio_a;
  logic [PEC_CT_W-1:0]  ratio_b;
  logic [PEC_VAL_W-1:0] cur_sum;
  modport req (output cur_a, cur_b, ratio_a, ratio_b, input cur_sum);
  modport rsp (input cur_a, cur_b, ratio_a, ratio_b, output cur_sum);
endinterface

// ### verilog/pec_scale_sum.sv
// Summer that rescales two transformer currents to the larger ratio
`timescale 1ns/100ps
module pec_scale_sum
  import pec_pkg::*;
(
  input  wire logic core_clk, // Clock
  input  wire logic nrst,     // Async reset, active low
  pec_scale_if.rsp  s         // Currents and ratios in, sum out
);
  localparam int unsigned PW = PEC_VAL_W + PEC_CT_W;
  logic [PW-1:0]        prod;
  logic [PEC_CT_W-1:0]  big;
  logic [PEC_VAL_W-1:0] scaled;
  logic [PEC_VAL_W-1:0] keep;
  logic [PEC_VAL_W:0]   total;
  // Larger ratio is the base; smaller side is scaled down to it
  always_comb begin
    if (s.ratio_a >= s.ratio_b) begin
      big  = s.ratio_a;
      keep = s.cur_a;
      prod = PW'(s.cur_b) * PW'(s.ratio_b);
    end else begin
      big  = s.ratio_b;
      keep = s.cur_b;
      prod = PW'(s.cur_a) * PW'(s.ratio_a);
    end
    scaled = (big == '0) ? '0 : PEC_VAL_W'(prod / PW'(big));
    total  = {1'b0, keep} + {1'b0, scaled};
  end
  // Saturate rather than wrap, so a large sum never looks small
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s.cur_sum <= '0;
    end else begin
      s.cur_sum <= total[PEC_VAL_W] ? '1 : total[PEC_VAL_W-1:0];
    end
  end
endmodule

// ### verilog/pec_element.sv
// Protection element: comparator, on/off delays, target and event outputs
// Functional notes
// - Pickup when quantity is beyond level, or inside range for multi-setting mode.
// - Operate only after pickup held continuously for the delay.
// - Analog quantity input, or single logic state in digital variant.
// - Eight setting groups; active group selects behaviour.
// - Control-class element ignores the active group.
// - Two-ratio sum uses larger rated input as base, rescales other.
// - Function comes out of reset disabled; active only when enabled. function_en is a plain input here, and the element's reset does not clear it.
// - Programmable on-delay between pickup and operate.
// - Programmable off-delay holds operate after pickup leaves.
// - Outputs default low; test runs only with permit high.
// - Permit low clears pickup and operate on the next clock; a latched target holds and a dropout event fires.
// - Block input is one term of the permit.
// - Target disabled: no target message or indicator.
// - Target self-reset: indication follows operate.
// - Target latched: indication holds until reset command.
// - Events enabled: pickup, dropout, operate events; disabled: none.
// - Dropout event on pickup falling edge, even while still operating.
// - Summed currents rescaled to one common ratio before adding.
`timescale 1ns/100ps
module pec_element
  import pec_pkg::*;
#(
  parameter int unsigned GROUPS = PEC_GROUPS, // Number of setting groups
  parameter bit          DIGITAL = 1'b0       // Digital variant: logic state input
)(
  input  wire logic                     core_clk,       // 40 MHz clock
  input  wire logic                     nrst,           // Async reset, active low
  input  wire logic                     function_en,    // Function setting enabled
  input  wire logic                     grouped,        // 1 grouped class, 0 control class
  input  wire logic [PEC_GRP_W-1:0]     active_group,   // Active setting group 0..7
  input  wire logic [PEC_GRP_W-1:0]     wr_group,       // Group written by set_wr
  input  wire logic                     set_wr,         // Settings write strobe
  input  wire pec_pkg::pec_group_s      set_data,       // Settings for wr_group
  input  wire pec_pkg::pec_cmp_e        cmp_mode,       // Over, under or range test
  input  wire pec_pkg::pec_target_e     target_mode,    // Target behaviour
  input  wire logic                     events_en,      // Event recording enabled
  input  wire logic                     sum_sel,        // Use summed two-CT current
  input  wire logic [PEC_VAL_W-1:0]     quantity,       // Measured actual value
  input  wire logic [PEC_VAL_W-1:0]     quantity_b,     // Second CT current
  input  wire logic [PEC_CT_W-1:0]      ratio_a,        // Ratio of first CT
  input  wire logic [PEC_CT_W-1:0]      ratio_b,        // Ratio of second CT
  input  wire logic                     logic_in,       // Digital variant input pin
  input  wire logic                     run_in,         // External permit term
  input  wire logic                     block_in,       // Block input, active high
  input  wire logic                     reset_cmd,      // Target reset command
  output logic                          pickup,         // Pickup flag
  output logic                          operate,        // Operate flag
  output logic                          target,         // Target indicator
  output logic                          pickup_event,   // Pickup event pulse
  output logic                          dropout_event,  // Dropout event pulse
  output logic                          operate_event   // Operate event pulse
);
  import pec_pkg::*;

  pec_group_s           grp [GROUPS];
  pec_group_s           cur;
  logic [PEC_VAL_W-1:0] meas;
  logic                 beyond;
  logic                 permit;
  logic                 li_s1;
  logic                 li_s2;
  logic [15:0]          div_cnt;
  logic                 tick;
  logic [PEC_DLY_W-1:0] on_cnt;
  logic [PEC_DLY_W-1:0] off_cnt;
  logic                 next_pickup;
  logic                 next_operate;
  logic                 latched;

  pec_scale_if sif ();
  assign sif.cur_a   = quantity;
  assign sif.cur_b   = quantity_b;
  assign sif.ratio_a = ratio_a;
  assign sif.ratio_b = ratio_b;

  pec_scale_sum u_sum (
    .core_clk (core_clk),
    .nrst     (nrst),
    .s        (sif)
  );

  // Setting groups held in flip-flops; control class always reads group 0
  genvar g;
  generate
    for (g = 0; g < GROUPS; g++) begin : g_grp
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          grp[g] <= '{pickup_lo: '0, pickup_hi: '1, pickup_delay: DLY_RESET, reset_delay: DLY_RESET};
        end else if (set_wr && wr_group == PEC_GRP_W'(g)) begin
          grp[g] <= set_data;
        end
      end
    end
  endgenerate

  assign cur  = grouped ? grp[active_group] : grp[0];
  assign meas = sum_sel ? sif.cur_sum : quantity;

  // Pin input crosses in through two flops
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      li_s1 <= 1'b0;
      li_s2 <= 1'b0;
    end else begin
      li_s1 <= logic_in;
      li_s2 <= li_s1;
    end
  end

  // Level test with no hysteresis: pickup follows the quantity directly
  always_comb begin
    if (DIGITAL) begin
      beyond = li_s2;
    end else begin
      case (cmp_mode)
        pec_cmp_over:  beyond = meas > cur.pickup_lo;
        pec_cmp_under: beyond = meas < cur.pickup_lo;
        pec_cmp_range: beyond = (meas >= cur.pickup_lo) && (meas <= cur.pickup_hi);
        default:       beyond = 1'b0;
      endcase
    end
  end

  assign permit = function_en && run_in && !block_in;

  // Millisecond timebase for the delay counters
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      div_cnt <= '0;
    end else if (div_cnt == TICK_DIV_LAST) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end
  assign tick = (div_cnt == TICK_DIV_LAST);

  always_comb begin
    next_pickup  = permit && beyond;
    next_operate = operate;
    if (!permit) begin
      next_operate = 1'b0;
    end else if (beyond) begin
      if (!operate && (on_cnt >= cur.pickup_delay)) begin
        next_operate = 1'b1;
      end
    end else if (operate && (off_cnt >= cur.reset_delay)) begin
      next_operate = 1'b0;
    end
  end

  // On-delay counts only while pickup is continuous; any gap restarts it
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      on_cnt <= '0;
    end else if (!permit || !beyond) begin
      on_cnt <= '0;
    end else if (tick && on_cnt != '1) begin
      on_cnt <= on_cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      off_cnt <= '0;
    end else if (!permit || beyond || !operate) begin
      off_cnt <= '0;
    end else if (tick && off_cnt != '1) begin
      off_cnt <= off_cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pickup  <= 1'b0;
      operate <= 1'b0;
    end else begin
      pickup  <= next_pickup;
      operate <= next_operate;
    end
  end

  // Latch: a new operate in the reset cycle wins over the clear
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      latched <= 1'b0;
    end else if (target_mode != pec_tgt_latched) begin
      latched <= 1'b0;
    end else if (next_operate) begin
      latched <= 1'b1;
    end else if (reset_cmd) begin
      latched <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      target <= 1'b0;
    end else begin
      case (target_mode)
        pec_tgt_disabled:   target <= 1'b0;
        pec_tgt_self_reset: target <= next_operate;
        pec_tgt_latched:    target <= next_operate || (latched && !reset_cmd);
        default:            target <= 1'b0;
      endcase
    end
  end

  // Dropout fires on pickup fall even while operate is still held
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pickup_event  <= 1'b0;
      dropout_event <= 1'b0;
      operate_event <= 1'b0;
    end else begin
      pickup_event  <= events_en && next_pickup && !pickup;
      dropout_event <= events_en && !next_pickup && pickup;
      operate_event <= events_en && next_operate && !operate;
    end
  end

  a_permit_clears: assert property (@(posedge core_clk) disable iff (!nrst)
    !permit |=> !pickup && !operate) else $error("outputs not cleared without permit");
  a_pickup_follows: assert property (@(posedge core_clk) disable iff (!nrst)
    permit && beyond |=> pickup) else $error("pickup missed");
  a_no_hyst: assert property (@(posedge core_clk) disable iff (!nrst)
    !beyond |=> !pickup) else $error("pickup held without cause");
  a_op_needs_pkp: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(operate) |-> pickup && $past(on_cnt) >= cur.pickup_delay) else $error("early operate");
  a_disabled_off: assert property (@(posedge core_clk) disable iff (!nrst)
    !function_en |=> !pickup && !operate) else $error("disabled element active");
  a_block_off: assert property (@(posedge core_clk) disable iff (!nrst)
    block_in |=> !pickup) else $error("block ignored");
  a_tgt_disabled: assert property (@(posedge core_clk) disable iff (!nrst)
    target_mode == pec_tgt_disabled |=> !target) else $error("target while disabled");
  a_tgt_self: assert property (@(posedge core_clk) disable iff (!nrst)
    target_mode == pec_tgt_self_reset |=> target == operate) else $error("self-reset target wrong");
  a_tgt_latch: assert property (@(posedge core_clk) disable iff (!nrst)
    target_mode == pec_tgt_latched && target && !reset_cmd |=> target || target_mode != pec_tgt_latched)
    else $error("latched target lost");
  a_no_events: assert property (@(posedge core_clk) disable iff (!nrst)
    !events_en |=> !pickup_event && !dropout_event && !operate_event) else $error("event while off");
  a_dpo_edge: assert property (@(posedge core_clk) disable iff (!nrst)
    events_en && $fell(pickup) |-> dropout_event) else $error("dropout event missing");
  a_offdelay_hold: assert property (@(posedge core_clk) disable iff (!nrst)
    operate && permit && !beyond && off_cnt < cur.reset_delay |=> operate) else $error("off-delay cut");
endmodule

// ### tb/pec_element_bench.sv
// Self-checking bench for the protection element comparator
`timescale 1ns/100ps
module pec_element_bench;
  import pec_pkg::*;
  logic                 core_clk, nrst, function_en, grouped, set_wr, events_en, sum_sel;
  logic                 logic_in, run_in, block_in, reset_cmd;
  logic                 pickup, operate, target, pickup_event, dropout_event, operate_event;
  logic [PEC_GRP_W-1:0] active_group, wr_group;
  logic [PEC_VAL_W-1:0] quantity, quantity_b;
  logic [PEC_CT_W-1:0]  ratio_a, ratio_b;
  pec_group_s           set_data;
  pec_cmp_e             cmp_mode;
  pec_target_e          target_mode;
  int                   err_count = 0;
  int                   samples_checked = 0;
  int                   n;
  // Quantities straddle lo=0x64 and hi=0xc8; bit k of a row is the pickup for qv[k]
  logic [15:0]          qv [4] = '{16'h0063, 16'h0064, 16'h00c8, 16'h00c9};
  logic [3:0]           cmp_tab [4] = '{4'hc, 4'h1, 4'h6, 4'h0};
  // Rows of {quantity, quantity_b, ratio_a, ratio_b}; an unscaled sum would pick up on all
  logic [55:0]          sum_tab [4] = '{56'h0064_0060_12c_064, 56'h0064_005a_12c_064,
                                        56'h0063_0064_064_12c, 56'h0063_005e_064_12c};
  logic [3:0]           sum_exp = 4'h5;

  pec_element u_pec_element (
    .core_clk, .nrst, .function_en, .grouped, .active_group, .wr_group, .set_wr, .set_data,
    .cmp_mode, .target_mode, .events_en, .sum_sel, .quantity, .quantity_b, .ratio_a, .ratio_b,
    .logic_in, .run_in, .block_in, .reset_cmd, .pickup, .operate, .target, .pickup_event,
    .dropout_event, .operate_event
  );

  always #12.5 core_clk = ~core_clk;

  task automatic chk(input logic [5:0] exp, input logic [5:0] mask);
    logic [5:0] got;
    got = {pickup, operate, target, pickup_event, dropout_event, operate_event};
    samples_checked++;
    if ((got & mask) !== (exp & mask)) begin
      err_count++;
      $display("mismatch at %0t: outputs %b expected %b mask %b", $time, got, exp, mask);
    end
  endtask

  task automatic chk_span(input int got, input int lo, input int hi);
    samples_checked++;
    if (got < lo || got > hi) begin
      err_count++;
      $display("mismatch at %0t: span %0d cycles outside %0d..%0d", $time, got, lo, hi);
    end
  endtask

  // Outputs are looked at on the falling edge so the launching edge has settled
  task automatic nxt(input logic [5:0] exp, input logic [5:0] mask = 6'h3f, input int cyc = 1);
    repeat (cyc) @(posedge core_clk);
    @(negedge core_clk);
    chk(exp, mask);
  endtask

  task automatic set_q(input logic [15:0] v);
    @(posedge core_clk);
    quantity <= v;
  endtask

  task automatic wr_set(input logic [2:0] g, input logic [15:0] lo, hi, pd, rd);
    @(posedge core_clk);
    set_wr <= 1'b1;
    wr_group <= g;
    set_data <= {lo, hi, pd, rd};
    @(posedge core_clk);
    set_wr <= 1'b0;
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    // Longest path is two one-tick delays of up to 40000 cycles each plus the setup
    #2_200_000;
    err_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    close_out();
  end

  initial begin
    core_clk = 1'b0;
    {nrst, function_en, grouped, set_wr, sum_sel, logic_in, block_in, reset_cmd} = 8'h00;
    {events_en, run_in} = 2'h3;
    {active_group, wr_group, set_data} = '0;
    {quantity, quantity_b} = 32'h01f4_0000;
    {ratio_a, ratio_b} = 24'h001_001;
    cmp_mode = pec_cmp_over;
    target_mode = pec_tgt_self_reset;
    @(negedge core_clk);
    chk(6'h00, 6'h3f);
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    // Reset level is zero, so only the disabled function keeps pickup away
    repeat (3) nxt(6'h00);
    wr_set(3'h0, 16'h0064, 16'hffff, 16'h0000, 16'h0000);
    @(posedge core_clk);
    function_en <= 1'b1;
    nxt(6'h3d);
    set_q(16'h0032);
    @(negedge core_clk);
    chk(6'h38, 6'h3f);
    nxt(6'h02);
    nxt(6'h00);
    for (int m = 0; m < 4; m++) begin
      @(posedge core_clk);
      target_mode <= pec_target_e'(m);
      quantity <= 16'h01f4;
      nxt({2'h3, (m == 1 || m == 2), 3'h5});
      set_q(16'h0032);
      nxt({2'h0, (m == 2), 3'h2});
      @(posedge core_clk);
      reset_cmd <= 1'b1;
      nxt(6'h00);
      @(posedge core_clk);
      reset_cmd <= 1'b0;
    end
    @(posedge core_clk);
    target_mode <= pec_tgt_self_reset;
    events_en <= 1'b0;
    quantity <= 16'h01f4;
    nxt(6'h38);
    set_q(16'h0032);
    nxt(6'h00);
    @(posedge core_clk);
    events_en <= 1'b1;
    quantity <= 16'h01f4;
    nxt(6'h3d);
    @(posedge core_clk);
    run_in <= 1'b0;
    nxt(6'h00, 6'h3d);
    @(posedge core_clk);
    run_in <= 1'b1;
    block_in <= 1'b1;
    repeat (2) nxt(6'h00, 6'h3d);
    @(posedge core_clk);
    block_in <= 1'b0;
    nxt(6'h3d);
    wr_set(3'h0, 16'h0064, 16'h00c8, 16'h0000, 16'h0000);
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 4; k++) begin
        @(posedge core_clk);
        cmp_mode <= pec_cmp_e'(m);
        quantity <= qv[k];
        nxt({cmp_tab[m][k], 5'h00}, 6'h20);
      end
    end
    for (int g = 0; g < 8; g++) begin
      wr_set(3'(g), 16'h0064 * 16'(g + 1), 16'hffff, 16'h0000, 16'h0000);
    end
    @(posedge core_clk);
    cmp_mode <= pec_cmp_over;
    quantity <= 16'h00fa;
    grouped <= 1'b1;
    for (int g = 0; g < 8; g++) begin
      @(posedge core_clk);
      active_group <= 3'(g);
      nxt({(g < 2), 5'h00}, 6'h20, 2);
    end
    @(posedge core_clk);
    grouped <= 1'b0;
    nxt(6'h20, 6'h20, 2);
    wr_set(3'h0, 16'h0082, 16'hffff, 16'h0000, 16'h0000);
    for (int r = 0; r < 4; r++) begin
      @(posedge core_clk);
      sum_sel <= 1'b1;
      {quantity, quantity_b, ratio_a, ratio_b} <= sum_tab[r];
      nxt({sum_exp[r], 5'h00}, 6'h20, 2);
    end
    @(posedge core_clk);
    sum_sel <= 1'b0;
    wr_set(3'h0, 16'h0064, 16'hffff, 16'h0001, 16'h0000);
    set_q(16'h01f4);
    nxt(6'h24);
    nxt(6'h20, 6'h20);
    // The divider runs free, so a one-tick on-delay lands anywhere within one tick
    n = 0;
    while (operate !== 1'b1 && n < 40100) begin
      @(negedge core_clk);
      n++;
    end
    chk_span(n, 1, 40002);
    chk(6'h39, 6'h3f);
    set_q(16'h0032);
    nxt(6'h02);
    wr_set(3'h0, 16'h0064, 16'hffff, 16'h0000, 16'h0001);
    set_q(16'h01f4);
    nxt(6'h3d);
    set_q(16'h0032);
    nxt(6'h1a);
    // One-tick off-delay: operate drops one cycle after the first tick, wherever it falls
    n = 0;
    while (operate === 1'b1 && n < 40100) begin
      @(negedge core_clk);
      n++;
    end
    chk_span(n, 1, 40002);
    chk(6'h00, 6'h3f);
    close_out();
  end
endmodule
